// file: src/xcvr_ctrl.sv
// control logic of a half-duplex differential transceiver
// assumes the bus comparator result arrives as a synchronous level and
// that the analogue driver and receiver follow the enables given here
`timescale 1ns/1ps

// Operation
// - standby when driver and receiver both disabled
// - brief disabled spells never cause standby
// - standby only after 300 ns continuous hold
// - leave standby when either side re-enables
// - detect polarity only when listening, not driving
// - decide only after full idle detection time
// - decision completes 44 to 76 ms after power-up
// - same correction on receive and transmit
// - detected polarity latched until next power-up
// - start uncorrected; reversed bias reads low
// - low at expiry inverts the receive path
// - invert host transmit data while correcting
// - detection repeats on every power-up
// - tied enables: high drives, low receives
// - permanent listen echoes own transmitted data
// - idle biased bus gives high receive output
// - idle detection time 44 to 76 ms
module xcvr_ctrl #(
    parameter int IDLE_CYC = xcvr_pkg::IDLE_DETECT_CYC
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic drive_enable_in,
    input  wire logic listen_enable_n,
    input  wire logic tx_valid,
    output logic      tx_ready,
    input  wire logic tx_data,
    output logic      rx_data,
    output logic      rx_oe_n,
    input  wire logic bus_rx_in,
    output logic      bus_tx_out,
    output logic      bus_tx_oe_n,
    output logic      standby,
    output logic      detect_busy,
    output logic      polarity_latched,
    output logic      polarity_inverted
);

    // ==========================================================
    // declarations
    xcvr_pkg::stby_state_t              stby_state_r;
    xcvr_pkg::stby_state_t              stby_state_nxt;
    xcvr_pkg::pol_state_t               pol_state_r;
    xcvr_pkg::pol_state_t               pol_state_nxt;
    logic [xcvr_pkg::STBY_CNT_W-1:0]    stby_cnt_r;
    logic                               invert_r;
    logic                               invert_nxt;
    logic                               latched_r;
    logic                               off_both;
    logic                               listening;
    logic                               idle_run;
    logic                               idle_expired;
    logic                               bus_level_q;
    logic                               fifo_out_valid;
    logic                               fifo_out_ready;
    logic                               fifo_out_data;
    logic                               tx_bit_r;
    logic                               rx_data_r;
    logic                               rx_oe_n_r;
    logic                               bus_tx_r;
    logic                               bus_tx_oe_n_r;

    // ==========================================================
    // enable decoding
    // with tied enables, high makes a driver and low a receiver
    assign off_both  = xcvr_pkg::both_disabled(drive_enable_in, listen_enable_n);
    assign listening = xcvr_pkg::detect_window(drive_enable_in, listen_enable_n);

    // ==========================================================
    // standby: counter of continuous disabled cycles
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stby_cnt_r <= xcvr_pkg::STBY_CNT_ZERO;
        end else if (!off_both) begin
            stby_cnt_r <= xcvr_pkg::STBY_CNT_ZERO;
        end else if (stby_cnt_r != xcvr_pkg::STBY_HOLD_CNT) begin
            stby_cnt_r <= stby_cnt_r + xcvr_pkg::STBY_CNT_ONE;
        end
    end

    // standby next state
    always_comb begin
        stby_state_nxt = stby_state_r;
        case (stby_state_r)
            xcvr_pkg::STBY_ACTIVE: begin
                if (off_both) begin
                    stby_state_nxt = xcvr_pkg::STBY_PENDING;
                end
            end
            xcvr_pkg::STBY_PENDING: begin
                if (!off_both) begin
                    stby_state_nxt = xcvr_pkg::STBY_ACTIVE;
                end else if (stby_cnt_r == xcvr_pkg::STBY_HOLD_CNT - 1'b1) begin
                    stby_state_nxt = xcvr_pkg::STBY_ASLEEP;
                end
            end
            xcvr_pkg::STBY_ASLEEP: begin
                if (!off_both) begin
                    stby_state_nxt = xcvr_pkg::STBY_ACTIVE;
                end
            end
            default: begin
                stby_state_nxt = xcvr_pkg::STBY_ACTIVE;
            end
        endcase
    end

    // standby state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stby_state_r <= xcvr_pkg::STBY_ACTIVE;
        end else begin
            stby_state_r <= stby_state_nxt;
        end
    end

    // standby flag from a flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            standby <= 1'b0;
        end else begin
            standby <= (stby_state_nxt == xcvr_pkg::STBY_ASLEEP);
        end
    end

    // ==========================================================
    // polarity detection: idle timer runs only in the listen window
    assign idle_run = listening && (pol_state_r == xcvr_pkg::POL_WATCH);

    idle_timer #(
        .LIMIT(IDLE_CYC)
    ) u_idle (
        .clk     (clk),
        .nrst    (nrst),
        .run     (idle_run),
        .level   (bus_rx_in),
        .expired (idle_expired),
        .level_q (bus_level_q)
    );

    // polarity next state and decision
    always_comb begin
        pol_state_nxt = pol_state_r;
        invert_nxt    = invert_r;
        case (pol_state_r)
            xcvr_pkg::POL_WAIT: begin
                // wait for the slave to listen with its driver off
                if (listening) begin
                    pol_state_nxt = xcvr_pkg::POL_WATCH;
                end
            end
            xcvr_pkg::POL_WATCH: begin
                if (!listening) begin
                    pol_state_nxt = xcvr_pkg::POL_WAIT;
                end else if (idle_expired) begin
                    // quiet for the full time: low level means crossed pair
                    pol_state_nxt = xcvr_pkg::POL_LATCHED;
                    invert_nxt    = !bus_level_q;
                end
            end
            xcvr_pkg::POL_LATCHED: begin
                pol_state_nxt = xcvr_pkg::POL_LATCHED;
            end
            default: begin
                pol_state_nxt = xcvr_pkg::POL_WAIT;
            end
        endcase
    end

    // polarity state register; reset is the only way back
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pol_state_r <= xcvr_pkg::POL_WAIT;
        end else begin
            pol_state_r <= pol_state_nxt;
        end
    end

    // inversion flag: uncorrected until decided, then held
    always_ff @(posedge clk) begin
        if (!nrst) begin
            invert_r <= xcvr_pkg::INVERT_RST;
        end else if (pol_state_r != xcvr_pkg::POL_LATCHED) begin
            invert_r <= invert_nxt;
        end
    end

    // latched flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            latched_r <= 1'b0;
        end else if (pol_state_nxt == xcvr_pkg::POL_LATCHED) begin
            latched_r <= 1'b1;
        end
    end

    assign polarity_latched  = latched_r;
    assign polarity_inverted = invert_r;
    assign detect_busy       = (pol_state_r == xcvr_pkg::POL_WATCH);

    // ==========================================================
    // receive path: bus level corrected by the shared flag
    // the receiver still listens while the driver sends, so with
    // listen held active the host sees its own frame echoed
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_data_r <= xcvr_pkg::LINE_IDLE;
        end else begin
            rx_data_r <= bus_rx_in ^ invert_r;
        end
    end

    // receive output enable follows the listen enable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_oe_n_r <= 1'b1;
        end else begin
            rx_oe_n_r <= listen_enable_n || (stby_state_nxt == xcvr_pkg::STBY_ASLEEP);
        end
    end

    assign rx_data = rx_data_r;
    assign rx_oe_n = rx_oe_n_r;

    // ==========================================================
    // transmit path: host bits buffered, drained one per cycle
    // while the driver is enabled; disabled driver stalls the drain
    // so the buffer fills and tx_ready drops back to the host
    assign fifo_out_ready = drive_enable_in;

    bit_fifo #(
        .WIDTH(xcvr_pkg::FIFO_WIDTH),
        .DEPTH(xcvr_pkg::FIFO_DEPTH)
    ) u_txq (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // current host bit; holds the last one when the buffer runs dry
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_bit_r <= xcvr_pkg::LINE_IDLE;
        end else if (fifo_out_valid && fifo_out_ready) begin
            tx_bit_r <= fifo_out_data;
        end
    end

    // driver data: inverted while correction is active
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus_tx_r <= xcvr_pkg::LINE_IDLE;
        end else if (fifo_out_valid && fifo_out_ready) begin
            bus_tx_r <= fifo_out_data ^ invert_r;
        end else begin
            bus_tx_r <= tx_bit_r ^ invert_r;
        end
    end

    // driver enable, low while driving
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus_tx_oe_n_r <= 1'b1;
        end else begin
            bus_tx_oe_n_r <= !drive_enable_in;
        end
    end

    assign bus_tx_out  = bus_tx_r;
    assign bus_tx_oe_n = bus_tx_oe_n_r;

endmodule

// file: src/xcvr_pkg.sv
// constants, types and helpers shared by the transceiver control logic
// assumes a single 125 MHz clock and a synchronous active-low reset
package xcvr_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS          = 8;
    localparam int STBY_IGNORE_NS         = 100;
    localparam int STBY_HOLD_NS           = 300;
    // brief disabled spells up to this count never reach standby
    localparam int STBY_IGNORE_CYC        = STBY_IGNORE_NS / CLK_PERIOD_NS;
    // least hold time rounds up to whole cycles
    localparam int STBY_HOLD_CYC          = (STBY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STBY_CNT_W             = 6;
    localparam logic [STBY_CNT_W-1:0] STBY_HOLD_CNT   = STBY_CNT_W'(STBY_HOLD_CYC);
    localparam logic [STBY_CNT_W-1:0] STBY_CNT_ZERO   = 6'h00;
    localparam logic [STBY_CNT_W-1:0] STBY_CNT_ONE    = 6'h01;

    // ==========================================================
    // idle detection time (milliseconds)
    localparam int IDLE_DETECT_TIME_MIN_MS = 44;
    localparam int IDLE_DETECT_TIME_MS     = 58;
    localparam int IDLE_DETECT_TIME_MAX_MS = 76;
    localparam int NS_PER_MS               = 1000000;
    localparam int IDLE_DETECT_CYC = IDLE_DETECT_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int IDLE_CNT_W              = 24;

    // ==========================================================
    // buffering and reset values
    localparam int   FIFO_WIDTH  = 1;
    localparam int   FIFO_DEPTH  = 32;
    localparam logic INVERT_RST  = 1'b0;
    localparam logic LINE_IDLE   = 1'b1;

    // ==========================================================
    // state types
    typedef enum logic [1:0] {STBY_ACTIVE, STBY_PENDING, STBY_ASLEEP} stby_state_t;
    typedef enum logic [1:0] {POL_WAIT, POL_WATCH, POL_LATCHED} pol_state_t;

    // driver off and receiver off together
    function automatic logic both_disabled(input logic de, input logic re_n);
        return !de && re_n;
    endfunction

    // receiver on and driver off: the only detection window
    function automatic logic detect_window(input logic de, input logic re_n);
        return !de && !re_n;
    endfunction

endpackage

// file: src/bit_fifo.sv
// synchronous FIFO with valid/ready on both sides
// assumes one clock; full and empty are exact
`timescale 1ns/1ps
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // ==========================================================
    // handshakes
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// file: src/idle_timer.sv
// counts an uninterrupted quiet spell on a bus level
// assumes level is synchronous to clk; run low holds the timer cleared
`timescale 1ns/1ps
module idle_timer #(
    parameter int LIMIT = xcvr_pkg::IDLE_DETECT_CYC
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic run,
    input  wire logic level,
    output logic      expired,
    output logic      level_q
);
    localparam logic [xcvr_pkg::IDLE_CNT_W-1:0] LAST =
        xcvr_pkg::IDLE_CNT_W'(LIMIT - 1);

    logic [xcvr_pkg::IDLE_CNT_W-1:0] cnt_r;
    logic                            level_r;
    logic                            done_r;

    // previous level for edge detection
    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_r <= xcvr_pkg::LINE_IDLE;
        end else begin
            level_r <= level;
        end
    end

    // restart on any edge; one expiry pulse per quiet spell
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r   <= '0;
            done_r  <= 1'b0;
            expired <= 1'b0;
        end else if (!run || (level != level_r)) begin
            cnt_r   <= '0;
            done_r  <= 1'b0;
            expired <= 1'b0;
        end else if (!done_r && (cnt_r == LAST)) begin
            done_r  <= 1'b1;
            expired <= 1'b1;
        end else begin
            expired <= 1'b0;
            if (!done_r) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign level_q = level_r;
endmodule

// file: tb/xcvr_ctrl_sva.sv
// concurrent checks on the transceiver control ports
// assumes it is bound to xcvr_ctrl and sees only its ports
`timescale 1ns/1ps
module xcvr_ctrl_chk #(
    parameter int IDLE_CYC = 20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic drive_enable_in,
    input wire logic listen_enable_n,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_data,
    input wire logic rx_data,
    input wire logic rx_oe_n,
    input wire logic bus_rx_in,
    input wire logic bus_tx_out,
    input wire logic bus_tx_oe_n,
    input wire logic standby,
    input wire logic detect_busy,
    input wire logic polarity_latched,
    input wire logic polarity_inverted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [5:0]  dis_cnt_r;
    logic [31:0] quiet_cnt_r;
    logic        bus_q_r;

    // ==========================================
    // helper counters
    // consecutive samples with both sides disabled, saturating
    always_ff @(posedge clk) begin
        if (!nrst || drive_enable_in || !listen_enable_n) begin
            dis_cnt_r <= 6'h00;
        end else if (dis_cnt_r != 6'h3F) begin
            dis_cnt_r <= dis_cnt_r + 6'h01;
        end
    end
    // quiet cycles inside the detection window
    always_ff @(posedge clk) begin
        bus_q_r <= bus_rx_in;
        if (!nrst || drive_enable_in || listen_enable_n || bus_rx_in != bus_q_r) begin
            quiet_cnt_r <= 32'h0;
        end else begin
            quiet_cnt_r <= quiet_cnt_r + 32'h1;
        end
    end

    // ==========================================
    // assertions
    stby_enter_a: assert property (dis_cnt_r == 6'h28 |-> standby)
        else $error("standby missing after long disabled spell");
    stby_brief_a: assert property (standby |-> dis_cnt_r > 6'h0C)
        else $error("standby after a brief disabled spell");
    stby_hold_a: assert property ($rose(standby) |-> dis_cnt_r >= 6'h25)
        else $error("standby before the hold time");
    stby_exit_a: assert property (standby && (drive_enable_in || !listen_enable_n)
        |=> !standby)
        else $error("standby kept after re-enable");
    watch_start_a: assert property ($rose(detect_busy)
        |-> $past(!drive_enable_in && !listen_enable_n))
        else $error("detection outside the listen window");
    quiet_span_a: assert property ($rose(polarity_latched)
        |-> quiet_cnt_r >= 32'(IDLE_CYC - 2))
        else $error("decision before full idle time");
    decide_bound_a: assert property (quiet_cnt_r == 32'(IDLE_CYC + 8)
        |-> polarity_latched)
        else $error("decision late");
    decide_value_a: assert property ($rose(polarity_latched)
        |-> polarity_inverted == !$past(bus_rx_in))
        else $error("wrong polarity decision");
    no_early_inv_a: assert property (!polarity_latched |-> !polarity_inverted)
        else $error("inversion before decision");
    latch_hold_a: assert property (polarity_latched
        |=> polarity_latched && $stable(polarity_inverted))
        else $error("latched polarity changed");
    rx_path_a: assert property ($past(nrst)
        |-> rx_data == ($past(bus_rx_in) ^ $past(polarity_inverted)))
        else $error("receive path not corrected");
    drv_oe_a: assert property ($past(nrst) |-> bus_tx_oe_n == !$past(drive_enable_in))
        else $error("driver enable wrong");

    // ==========================================
    // covers
    stby_c: cover property ($rose(standby));
    inv_c: cover property ($rose(polarity_inverted));
    full_c: cover property (!tx_ready);
endmodule

bind xcvr_ctrl xcvr_ctrl_chk #(.IDLE_CYC(IDLE_CYC)) i_xcvr_ctrl_chk (
    .clk(clk), .nrst(nrst), .drive_enable_in(drive_enable_in),
    .listen_enable_n(listen_enable_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_data(rx_data), .rx_oe_n(rx_oe_n), .bus_rx_in(bus_rx_in),
    .bus_tx_out(bus_tx_out), .bus_tx_oe_n(bus_tx_oe_n), .standby(standby),
    .detect_busy(detect_busy), .polarity_latched(polarity_latched),
    .polarity_inverted(polarity_inverted)
);

// file: tb/host_model.sv
// host controller model offering transmit bits one at a time
// assumes calls start just after a rising clock edge
`timescale 1ns/1ps
module host_model (
    input  wire logic clk,
    input  wire logic tx_ready,
    output logic      tx_valid,
    output logic      tx_data
);
    logic ready_q;
    // ready as it stands at the coming rising edge
    always @(negedge clk) ready_q = tx_ready;
    initial begin
        tx_valid = 1'b0;
        tx_data  = 1'b0;
    end
    // offer one bit and hold it until taken; valid stays up
    task automatic send_bit(input logic b);
        tx_valid = 1'b1;
        tx_data  = b;
        do @(posedge clk); while (ready_q !== 1'b1);
        #1;
    endtask
    // withdraw the offer
    task automatic quiet();
        tx_valid = 1'b0;
    endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the transceiver control block
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
module testbench;
    localparam int IDLE = 20;
    localparam logic [31:0] PAT = 32'h5A3C96E1; // no long runs of equal bits
    logic clk, nrst, de, ren_n, bus_level;
    logic tx_valid, tx_ready, tx_data, rx_data, rx_oe_n, bus_rx_in;
    logic bus_tx_out, bus_tx_oe_n, standby, detect_busy, pol_lat, pol_inv;
    int   errors, checked;

    // ==========================================
    // bus: own driver when enabled, else the bias level
    assign bus_rx_in = (bus_tx_oe_n === 1'b0) ? bus_tx_out : bus_level;
    xcvr_ctrl #(.IDLE_CYC(IDLE)) i_xcvr_ctrl (
        .clk(clk), .nrst(nrst), .drive_enable_in(de), .listen_enable_n(ren_n),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_data(rx_data),
        .rx_oe_n(rx_oe_n), .bus_rx_in(bus_rx_in), .bus_tx_out(bus_tx_out),
        .bus_tx_oe_n(bus_tx_oe_n), .standby(standby), .detect_busy(detect_busy),
        .polarity_latched(pol_lat), .polarity_inverted(pol_inv));
    host_model i_host_model (.clk(clk), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data));
    always #4 clk = ~clk;

    // ==========================================
    // helpers
    task automatic check(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset(input logic bias);
        nrst = 1'b0;
        bus_level = bias;
        step(8);
        nrst = 1'b1;
    endtask
    // listen with driver off, wait bounded for the decision
    task automatic await_latch(output int n);
        de = 1'b0;
        ren_n = 1'b0;
        n = 0;
        while (pol_lat !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
    endtask
    // fill the buffer with the driver off, then drain and find the pattern
    task automatic tx_burst(input logic inv, input logic ren);
        logic [47:0] seen;
        logic        found;
        for (int i = 31; i >= 0; i--) i_host_model.send_bit(PAT[i]);
        i_host_model.quiet();
        check("tx_ready full", 1'b0, tx_ready);
        de = 1'b1; // bias held still until now
        ren_n = ren;
        for (int i = 0; i < 48; i++) begin
            step(1);
            seen = {seen[46:0], bus_tx_out};
        end
        found = 1'b0;
        for (int o = 0; o <= 16; o++) if (seen[o +: 32] === (PAT ^ {32{inv}})) found = 1'b1;
        check("tx sequence", 1'b1, found);
        check("tx_ready drained", 1'b1, tx_ready);
        de = 1'b0;
        ren_n = 1'b0;
    endtask
    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic test_reset();
        do_reset(1'b1);
        check("latched", 1'b0, pol_lat);
        check("inverted", 1'b0, pol_inv);
        check("standby", 1'b0, standby);
        check("tx_ready", 1'b1, tx_ready);
        check("bus_tx_oe_n", 1'b1, bus_tx_oe_n);
        $display("test_reset done");
    endtask
    task automatic test_standby();
        de = 1'b0;
        ren_n = 1'b1;
        step(12);
        ren_n = 1'b0;
        step(3);
        check("standby brief", 1'b0, standby);
        ren_n = 1'b1;
        step(35);
        check("standby early", 1'b0, standby);
        step(5);
        check("standby entered", 1'b1, standby);
        check("rx_oe_n asleep", 1'b1, rx_oe_n);
        de = 1'b1;
        step(2);
        check("standby left", 1'b0, standby);
        de = 1'b0;
        $display("test_standby done");
    endtask
    task automatic test_reversed();
        int n;
        do_reset(1'b0);
        de = 1'b0;
        ren_n = 1'b0;
        step(10);
        check("rx uncorrected", 1'b0, rx_data);
        check("detect_busy", 1'b1, detect_busy);
        check("rx_oe_n listening", 1'b0, rx_oe_n);
        bus_level = 1'b1;
        step(1);
        bus_level = 1'b0;
        await_latch(n);
        check("restart on edge", 1'b1, n >= IDLE);
        step(1);
        check("inverted", 1'b1, pol_inv);
        check("rx corrected", 1'b1, rx_data);
        bus_level = 1'b1;
        step(IDLE + 10);
        check("rx follows", 1'b0, rx_data);
        check("inversion kept", 1'b1, pol_inv);
        tx_burst(1'b1, 1'b0);
        $display("test_reversed done");
    endtask
    task automatic test_correct();
        int n;
        do_reset(1'b1);
        await_latch(n);
        step(1);
        check("latched", 1'b1, pol_lat);
        check("not inverted", 1'b0, pol_inv);
        check("rx failsafe", 1'b1, rx_data);
        tx_burst(1'b0, 1'b1);
        $display("test_correct done");
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        de = 1'b0;
        ren_n = 1'b1;
        bus_level = 1'b1;
        errors = 0;
        checked = 0;
        test_reset();
        test_standby();
        test_reversed();
        test_correct();
        conclude();
    end
    initial begin
        #40000;
        errors++;
        $display("[FAIL] watchdog expected end seen timeout");
        conclude();
    end
endmodule
